// [core/novp_pkg.sv]
// Package for the neutral overvoltage pickup stage: APB map, defaults, codes, carriers.
// Assumes a 20 MHz system clock and a 32-bit APB master.
package novp_pkg;
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned UPDATE_TIME_NS = 5000000;
  localparam int unsigned UPDATE_CYCLES  = UPDATE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [18:0] MAX_TICKS      = 19'h57E40;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_THRESH  = 8'h04;
  localparam logic [7:0] OFS_DELAY   = 8'h08;
  localparam logic [7:0] OFS_RELEASE = 8'h0C;
  localparam logic [7:0] OFS_DIAL    = 8'h10;
  localparam logic [7:0] OFS_EXPO    = 8'h14;
  localparam logic [7:0] OFS_VT      = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_RATIO   = 8'h20;
  localparam logic [7:0] OFS_EXPECT  = 8'h24;
  localparam logic [7:0] OFS_REMAIN  = 8'h28;
  localparam logic [7:0] OFS_LEVEL   = 8'h2C;
  // ==========================================================================
  // Reset values and limits (threshold in 0.01 % of nominal, times in 5 ms ticks)
  localparam logic [13:0] THRESH_RST  = 14'h07D0;
  localparam logic [13:0] THRESH_MIN  = 14'h0064;
  localparam logic [13:0] THRESH_MAX  = 14'h26AC;
  localparam logic [18:0] DELAY_RST   = 19'h00008;
  localparam logic [14:0] RELEASE_RST = 15'h000C;
  localparam logic [12:0] DIAL_RST    = 13'h0005;
  localparam logic [11:0] EXPO_RST    = 12'h064;
  localparam logic [19:0] VT_RST      = 20'h02710;
  localparam logic [10:0] CTRL_RST    = 11'h4C0;
  localparam logic [9:0]  Q10_ONE     = 10'h3FF;
  // ==========================================================================
  // Codes
  typedef enum logic [1:0] {SRC_NONE, SRC_CALC, SRC_AUX_A, SRC_AUX_B} novp_src_t;
  typedef enum logic [1:0] {FRC_NORMAL, FRC_START, FRC_TRIP, FRC_BLOCKED} novp_force_t;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } novp_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } novp_apb_rsp_t;
  typedef struct packed {
    logic signed [15:0] phase_a_voltage;
    logic signed [15:0] phase_b_voltage;
    logic signed [15:0] phase_c_voltage;
    logic [15:0]        aux_a;
    logic [15:0]        aux_b;
  } novp_meas_t;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } novp_flags_t;
endpackage : novp_pkg

// [core/novp_stage.sv]
// Neutral overvoltage pickup stage with APB register access.
// Assumes measurement words from same-clock logic; block input arrives asynchronously.
`timescale 1ns/1ps
module novp_stage #(
  parameter int unsigned UPDATE_CYC = novp_pkg::UPDATE_CYCLES
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   arst_n_in,
  input  wire novp_pkg::novp_apb_req_t apb_in,
  output      novp_pkg::novp_apb_rsp_t apb_out,
  input  wire novp_pkg::novp_meas_t    meas_in,
  input  wire logic                   block_in,
  output      novp_pkg::novp_flags_t   flags_out
);
  localparam int TW = $clog2(UPDATE_CYC);
  localparam logic [18:0] MAX_T      = novp_pkg::MAX_TICKS;
  localparam logic [10:0] Q10_ONE_P1 = 11'(novp_pkg::Q10_ONE) + 11'h001;
  typedef enum {ST_IDLE, ST_START, ST_RELEASE, ST_TRIP, ST_BLOCKED} novp_stage_t;
  typedef struct packed {
    logic [TW-1:0]        tick_cnt;
    logic                 tick;
    logic                 blk_s1;
    logic                 blk_s2;
    logic [10:0]          ctrl;
    logic [13:0]          thresh;
    logic [18:0]          delay;
    logic [14:0]          release_dly;
    logic [12:0]          dial;
    logic [11:0]          expo;
    logic [19:0]          vt;
    logic [15:0]          meas;
    novp_pkg::novp_src_t  src;
    logic                 pick;
    novp_stage_t          stage;
    logic [18:0]          op_cnt;
    logic [14:0]          rel_cnt;
    logic [18:0]          target;
    logic [16:0]          ratio;
    logic [23:0]          pw_acc;
    logic [4:0]           pw_left;
    logic [23:0]          pw_res;
    novp_pkg::novp_apb_rsp_t rsp;
    novp_pkg::novp_flags_t   flags;
  } novp_state_t;
  // ctrl: [1:0] source, [3:2] force, [4] force en, [5] inverse mode, [6] delayed release,
  // [7] timer held through release, [8] aux A residual, [9] aux B residual, [10] LN wired
  novp_state_t st;
  novp_state_t next_st;

  logic signed [17:0] phase_sum;
  logic [17:0]        calc_mag;
  logic [15:0]        sel_mag;
  logic               next_pick;
  logic [19:0]        ratio_q10;
  logic [43:0]        pw_prod;
  logic [23:0]        inverse_time_mode_ticks;
  logic [18:0]        next_target;
  logic [4:0]         expo_int;
  logic               blk;
  logic               tmr_hit;
  logic [31:0]        rd;
  logic               rd_ok;

  always_comb
  begin
    next_st = st;
    // ==========================================================================
    // Update tick and block synchroniser
    next_st.blk_s1 = block_in;
    next_st.blk_s2 = st.blk_s1;
    next_st.tick   = (st.tick_cnt == TW'(UPDATE_CYC - 1));
    next_st.tick_cnt = next_st.tick ? '0 : TW'(st.tick_cnt + 1'b1);
    blk = st.blk_s2;
    // ==========================================================================
    // Source resolution and magnitude
    phase_sum = 18'(meas_in.phase_a_voltage) + 18'(meas_in.phase_b_voltage)
              + 18'(meas_in.phase_c_voltage);
    // Phase words are 0.01 % of phase nominal, so a third of the sum is already
    // on the phase-nominal scale of the residual
    calc_mag = (phase_sum < 0) ? 18'(-phase_sum) / 18'd3 : 18'(phase_sum) / 18'd3;
    case (st.ctrl[1:0])
      2'h1:    next_st.src = novp_pkg::SRC_CALC;
      2'h2:    next_st.src = st.ctrl[8] ? novp_pkg::SRC_AUX_A : novp_pkg::SRC_NONE;
      2'h3:    next_st.src = st.ctrl[9] ? novp_pkg::SRC_AUX_B : novp_pkg::SRC_NONE;
      default: next_st.src = st.ctrl[10] ? novp_pkg::SRC_CALC :
                             st.ctrl[8]  ? novp_pkg::SRC_AUX_A :
                             st.ctrl[9]  ? novp_pkg::SRC_AUX_B : novp_pkg::SRC_NONE;
    endcase
    case (st.src)
      novp_pkg::SRC_CALC:  sel_mag = (calc_mag > 18'h0FFFF) ? 16'hFFFF : calc_mag[15:0];
      novp_pkg::SRC_AUX_A: sel_mag = meas_in.aux_a;
      novp_pkg::SRC_AUX_B: sel_mag = meas_in.aux_b;
      default:             sel_mag = 16'h0000;
    endcase
    // ==========================================================================
    // Ratio and inverse-time power, iterated one multiply per clock
    ratio_q10 = 20'((36'(st.meas) << 10) / 36'(st.thresh));
    next_st.ratio = (32'(st.meas) * 32'd100 / 32'(st.thresh) > 32'd125000) ? 17'h1E848
                  : 17'(32'(st.meas) * 32'd100 / 32'(st.thresh));
    expo_int = (st.expo < 12'h096) ? 5'h01 : 5'((st.expo + 12'h032) / 12'h064);
    pw_prod  = 44'(st.pw_acc) * 44'(ratio_q10);
    if (st.pw_left == 5'h00)
    begin
      next_st.pw_res  = st.pw_acc;
      next_st.pw_acc  = 24'({Q10_ONE_P1});
      next_st.pw_left = expo_int;
    end
    else
    begin
      next_st.pw_acc  = (pw_prod[43:34] != '0) ? 24'hFFFFFF : pw_prod[33:10];
      next_st.pw_left = st.pw_left - 5'h01;
    end
    // Dial is 0.01 s = 2 ticks; a ratio at or below one gets the longest time, MAX_T
    inverse_time_mode_ticks = (st.pw_res <= 24'h000400) ? 24'(MAX_T)
               : 24'((32'(st.dial) * 32'd2048) / 32'(st.pw_res - 24'h000400));
    if (st.ctrl[5])
      next_target = (inverse_time_mode_ticks > 24'(MAX_T)) ? MAX_T : inverse_time_mode_ticks[18:0];
    else
      next_target = st.delay;
    // ==========================================================================
    // Pick-up with hysteresis and stage sequencing, once per update
    next_pick = st.pick ? (32'(sel_mag) * 32'd100 >= 32'(st.thresh) * 32'd97)
                        : (sel_mag > 16'(st.thresh));
    tmr_hit = (32'(st.op_cnt) + 32'd1 >= 32'(next_target));
    if (st.tick)
    begin
      next_st.meas   = sel_mag;
      next_st.pick   = next_pick;
      next_st.target = next_target;
      case (st.stage)
        ST_IDLE:
          if (next_pick)
          begin
            next_st.op_cnt = '0;
            if (blk)
              next_st.stage = ST_BLOCKED;
            else
              next_st.stage = (next_target == '0) ? ST_TRIP : ST_START;
          end
        ST_START, ST_RELEASE:
          if (next_pick && !blk && (st.stage == ST_START || next_st.stage == ST_RELEASE))
          begin
            next_st.op_cnt = st.op_cnt + 19'h00001;
            next_st.stage  = tmr_hit ? ST_TRIP : ST_START;
          end
          else if (st.stage == ST_START)
          begin
            next_st.rel_cnt = '0;
            next_st.stage   = st.ctrl[6] ? ST_RELEASE : ST_IDLE;
            if (!(st.ctrl[6] && st.ctrl[7]))
              next_st.op_cnt = '0;
          end
          else if (32'(st.rel_cnt) + 32'd1 >= 32'(st.release_dly))
          begin
            next_st.stage  = ST_IDLE;
            next_st.op_cnt = '0;
          end
          else
            next_st.rel_cnt = st.rel_cnt + 15'h0001;
        default:
          if (!next_pick)
            next_st.stage = ST_IDLE;
      endcase
      if (st.ctrl[4])
      begin
        next_st.flags.start   = (st.ctrl[3:2] == novp_pkg::FRC_START) ||
                                (st.ctrl[3:2] == novp_pkg::FRC_TRIP);
        next_st.flags.trip    = (st.ctrl[3:2] == novp_pkg::FRC_TRIP);
        next_st.flags.blocked = (st.ctrl[3:2] == novp_pkg::FRC_BLOCKED);
      end
      else
      begin
        next_st.flags.start   = (next_st.stage == ST_START) || (next_st.stage == ST_RELEASE)
                             || (next_st.stage == ST_TRIP);
        next_st.flags.trip    = (next_st.stage == ST_TRIP);
        next_st.flags.blocked = (next_st.stage == ST_BLOCKED);
      end
    end
    // ==========================================================================
    // APB slave: zero wait states, data and ready registered in the setup cycle
    rd_ok = 1'b1;
    rd    = 32'h00000000;
    if (apb_in.paddr == novp_pkg::OFS_CTRL)         rd = 32'(st.ctrl);
    else if (apb_in.paddr == novp_pkg::OFS_THRESH)  rd = 32'(st.thresh);
    else if (apb_in.paddr == novp_pkg::OFS_DELAY)   rd = 32'(st.delay);
    else if (apb_in.paddr == novp_pkg::OFS_RELEASE) rd = 32'(st.release_dly);
    else if (apb_in.paddr == novp_pkg::OFS_DIAL)    rd = 32'(st.dial);
    else if (apb_in.paddr == novp_pkg::OFS_EXPO)    rd = 32'(st.expo);
    else if (apb_in.paddr == novp_pkg::OFS_VT)      rd = 32'(st.vt);
    else if (apb_in.paddr == novp_pkg::OFS_STATUS)
      rd = {26'h0, st.pick, st.flags.blocked, st.flags.trip, st.flags.start, st.src};
    else if (apb_in.paddr == novp_pkg::OFS_RATIO)   rd = 32'(st.ratio);
    else if (apb_in.paddr == novp_pkg::OFS_EXPECT)  rd = 32'(st.target);
    else if (apb_in.paddr == novp_pkg::OFS_REMAIN)
      rd = (st.stage == ST_START || st.stage == ST_RELEASE)
         ? 32'(signed'(20'(st.target) - 20'(st.op_cnt))) : 32'h00000000;
    else if (apb_in.paddr == novp_pkg::OFS_LEVEL)
      rd = (st.src == novp_pkg::SRC_NONE) ? 32'h00000000
         : 32'((40'(st.thresh) * 40'(st.vt)) / 40'd1000);
    else
      rd_ok = 1'b0;
    next_st.rsp.pready  = apb_in.psel && !apb_in.penable;
    next_st.rsp.pslverr = apb_in.psel && !apb_in.penable && !rd_ok;
    next_st.rsp.prdata  = (apb_in.psel && !apb_in.penable && !apb_in.pwrite) ? rd
                                                                              : 32'h00000000;
    // Writes land at the access edge; source and ratio follow on the next clock, pick-up and stage sequencing at the next update tick
    if (apb_in.psel && apb_in.penable && st.rsp.pready && apb_in.pwrite)
    begin
      if (apb_in.paddr == novp_pkg::OFS_CTRL)
      begin
        next_st.ctrl = apb_in.pwdata[10:0];
        if ((apb_in.pwdata[1:0] == 2'h2 && !apb_in.pwdata[8]) ||
            (apb_in.pwdata[1:0] == 2'h3 && !apb_in.pwdata[9]))
          next_st.ctrl[1:0] = st.ctrl[1:0];
      end
      else if (apb_in.paddr == novp_pkg::OFS_THRESH)
      begin
        if (apb_in.pwdata[13:0] >= novp_pkg::THRESH_MIN &&
            apb_in.pwdata[13:0] <= novp_pkg::THRESH_MAX && apb_in.pwdata[31:14] == '0)
          next_st.thresh = apb_in.pwdata[13:0];
      end
      else if (apb_in.paddr == novp_pkg::OFS_DELAY)
        next_st.delay = (apb_in.pwdata[18:0] > MAX_T) ? MAX_T : apb_in.pwdata[18:0];
      else if (apb_in.paddr == novp_pkg::OFS_RELEASE) next_st.release_dly = apb_in.pwdata[14:0];
      else if (apb_in.paddr == novp_pkg::OFS_DIAL)    next_st.dial = apb_in.pwdata[12:0];
      else if (apb_in.paddr == novp_pkg::OFS_EXPO)    next_st.expo = apb_in.pwdata[11:0];
      else if (apb_in.paddr == novp_pkg::OFS_VT)      next_st.vt = apb_in.pwdata[19:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st             <= '0;
      st.ctrl        <= novp_pkg::CTRL_RST;
      st.thresh      <= novp_pkg::THRESH_RST;
      st.delay       <= novp_pkg::DELAY_RST;
      st.release_dly <= novp_pkg::RELEASE_RST;
      st.dial        <= novp_pkg::DIAL_RST;
      st.expo        <= novp_pkg::EXPO_RST;
      st.vt          <= novp_pkg::VT_RST;
      st.target      <= novp_pkg::DELAY_RST;
      st.stage       <= ST_IDLE;
    end
    else
      st <= next_st;
  end

  assign apb_out   = st.rsp;
  assign flags_out = st.flags;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_tick_gap;
    st.tick ##1 (!st.tick)[*8];
  endsequence
  sequence s_forced(logic [1:0] m);
    st.tick && st.ctrl[4] && st.ctrl[3:2] == m;
  endsequence

  tick_spacing_a: assert property (st.tick |-> s_tick_gap)
    else $error("update tick repeats too soon");
  flags_on_tick_a: assert property (!$past(st.tick) |-> $stable(st.flags))
    else $error("flags changed between updates");
  pick_rise_a: assert property ($rose(st.pick) |-> st.meas > 16'(st.thresh))
    else $error("pick-up without exceeding threshold");
  pick_fall_a: assert property
    ($fell(st.pick) |-> 32'(st.meas) * 32'd100 < 32'(st.thresh) * 32'd97)
    else $error("pick-up released above 97 percent");
  calc_source_a: assert property
    ($past(st.tick) && $past(st.src) == novp_pkg::SRC_CALC && $past(calc_mag) < 18'h10000
     |-> st.meas == $past(calc_mag[15:0]))
    else $error("calculated residual wrong");
  force_trip_a: assert property (s_forced(novp_pkg::FRC_TRIP) |=>
    st.flags.trip && st.flags.start && !st.flags.blocked)
    else $error("forced trip not shown");
  zero_delay_a: assert property
    ($rose(st.flags.start) && !st.ctrl[4] && !st.ctrl[5] && st.target == '0 |-> st.flags.trip)
    else $error("zero delay did not trip with start");
  blocked_excl_a: assert property
    ($rose(st.flags.blocked) && !st.ctrl[4] |-> !st.flags.start)
    else $error("blocked raised together with start");
  release_hold_a: assert property
    (st.stage == ST_RELEASE && !st.ctrl[4] && $past(st.tick) |-> st.flags.start)
    else $error("start dropped during release delay");
  apb_ready_a: assert property
    (apb_in.psel && !apb_in.penable |=> st.rsp.pready ##1 !st.rsp.pready)
    else $error("apb answer not one cycle after setup");
endmodule : novp_stage

// [testbench/novp_far_side.sv]
// Far-side model: measurement path feeding the stage and trip output logic watching it.
// Assumes the testbench sets target magnitudes and the block request on the same clock.
`timescale 1ns/1ps
module novp_far_side (
  input  wire logic                  sys_clk_in,
  input  wire logic                  arst_n_in,
  input  wire novp_pkg::novp_meas_t  target_in,
  input  wire logic                  block_req_in,
  input  wire novp_pkg::novp_flags_t flags_in,
  output novp_pkg::novp_meas_t       meas_out,
  output logic                       block_out,
  output logic [7:0]                 trip_count_out
);
  logic trip_seen;
  // ==========================================================================
  // Words refresh every clock, so any update tick of the stage sees current values
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meas_out       <= '0;
      block_out      <= 1'b0;
      trip_seen      <= 1'b0;
      trip_count_out <= 8'h00;
    end
    else
    begin
      meas_out  <= target_in;
      block_out <= block_req_in;
      trip_seen <= flags_in.trip;
      if (flags_in.trip && !trip_seen)
        trip_count_out <= trip_count_out + 8'h01;
    end
  end
endmodule : novp_far_side

// [testbench/tb_top.sv]
// Testbench for the neutral overvoltage stage: APB tasks and directed checks.
// Assumes novp_far_side as the measurement path and a shortened update period.
`timescale 1ns/1ps
module tb_top;
  localparam int          UPD = 32;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic                    sys_clk_in;
  logic                    arst_n_in;
  novp_pkg::novp_apb_req_t req;
  novp_pkg::novp_apb_rsp_t rsp;
  novp_pkg::novp_meas_t    tgt;
  novp_pkg::novp_meas_t    meas;
  novp_pkg::novp_flags_t   flags;
  logic                    blk_req;
  logic                    blk;
  logic [7:0]              trips;
  int                      n_errors;
  int                      n_tests;
  int                      cyc;
  logic [31:0]             q;
  logic                    e;
  logic [31:0]             rv [7];
  // ==========================================================================
  // Clock and hang guard
  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  novp_stage #(.UPDATE_CYC(UPD)) dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .apb_in(req), .apb_out(rsp), .meas_in(meas), .block_in(blk), .flags_out(flags));
  novp_far_side far (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .target_in(tgt),
    .block_req_in(blk_req), .flags_in(flags), .meas_out(meas), .block_out(blk),
    .trip_count_out(trips));
  // ==========================================================================
  // Tasks
  task automatic conclude();
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held until pready is sampled high; no wait-state count assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk_in);
    req.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
    end
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q & m, x);
  endtask : rd
  task automatic fl(input logic [2:0] x, input string nm);
    chk(nm, {29'h0, flags}, {29'h0, x});
  endtask : fl
  task automatic settle(input int n);
    repeat (n * UPD) @(posedge sys_clk_in);
  endtask : settle
  // ==========================================================================
  // Main sequence
  initial
  begin
    arst_n_in = 1'b0;
    req = '0;
    tgt = '0;
    blk_req = 1'b0;
    cyc = 0;
    n_errors = 0;
    n_tests = 0;
    rv = '{32'h4C0, 32'h7D0, 32'h8, 32'hC, 32'h5, 32'h64, 32'h2710};
    repeat (20) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), ALL, rv[i], "reset value");
    rd(novp_pkg::OFS_LEVEL, ALL, 32'h4E20, "level");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    wr(novp_pkg::OFS_THRESH, 32'h32);
    wr(novp_pkg::OFS_THRESH, 32'h26AD);
    rd(novp_pkg::OFS_THRESH, ALL, 32'h7D0, "thresh range");
    wr(novp_pkg::OFS_THRESH, 32'h64);
    rd(novp_pkg::OFS_THRESH, ALL, 32'h64, "thresh min");
    wr(novp_pkg::OFS_THRESH, 32'h7D0);
    // One phase at 90 % gives a residual of 30 % of nominal
    wr(novp_pkg::OFS_DELAY, 32'h64);
    wr(novp_pkg::OFS_CTRL, 32'h4C1);
    tgt.phase_a_voltage <= 16'sh2328;
    settle(3);
    fl(3'b100, "calc start");
    rd(novp_pkg::OFS_STATUS, ALL, 32'h25, "calc status");
    rd(novp_pkg::OFS_RATIO, ALL, 32'h96, "ratio");
    rd(novp_pkg::OFS_EXPECT, ALL, 32'h64, "expect");
    // At most three updates into a 100-tick delay, so 97 to 100 ticks remain
    rd(novp_pkg::OFS_REMAIN, 32'hFFFFFFF8, 32'h60, "remain");
    wr(novp_pkg::OFS_THRESH, 32'hFA0);
    settle(2);
    rd(novp_pkg::OFS_RATIO, ALL, 32'h4B, "ratio rewritten");
    wr(novp_pkg::OFS_THRESH, 32'h7D0);
    settle(2);
    // Aux value set before the switch so the pick-up never drops in between
    tgt.aux_a <= 16'h07BC;
    wr(novp_pkg::OFS_CTRL, 32'h5C2);
    tgt.phase_a_voltage <= 16'sh0000;
    settle(3);
    rd(novp_pkg::OFS_STATUS, 32'h23, 32'h22, "above release");
    tgt.aux_a <= 16'h078A;
    settle(3);
    rd(novp_pkg::OFS_STATUS, 32'h23, 32'h02, "below release");
    fl(3'b100, "release hold");
    settle(12);
    fl(3'b000, "release end");
    wr(novp_pkg::OFS_CTRL, 32'h5C3);
    rd(novp_pkg::OFS_CTRL, ALL, 32'h5C2, "aux b refused");
    wr(novp_pkg::OFS_DELAY, 32'h0);
    tgt.aux_a <= 16'h0BB8;
    settle(3);
    fl(3'b110, "instant trip");
    chk("trip count", {24'h0, trips}, 32'h1);
    tgt.aux_a <= 16'h0000;
    settle(16);
    blk_req <= 1'b1;
    settle(1);
    tgt.aux_a <= 16'h0BB8;
    settle(3);
    fl(3'b001, "blocked");
    blk_req <= 1'b0;
    tgt.aux_a <= 16'h0000;
    settle(16);
    for (int f = 0; f < 4; f++)
    begin
      wr(novp_pkg::OFS_CTRL, 32'h4D0 | 32'(f << 2));
      settle(3);
      chk("forced", f == 0 ? {29'h0, flags} : {31'h0, flags[3 - f]}, {31'h0, f != 0});
    end
    wr(novp_pkg::OFS_CTRL, 32'h4C8);
    settle(3);
    fl(3'b000, "force off");
    wr(novp_pkg::OFS_CTRL, 32'h0C0);
    settle(2);
    rd(novp_pkg::OFS_STATUS, 32'h3, 32'h0, "no residual");
    wr(novp_pkg::OFS_CTRL, 32'h4C0);
    settle(2);
    rd(novp_pkg::OFS_STATUS, 32'h3, 32'h1, "fallback calc");
    // Residual at twice the threshold: 0.05 s / (2 - 1) is 10 ticks
    wr(novp_pkg::OFS_CTRL, 32'h4E0);
    tgt.phase_a_voltage <= 16'sh2EE0;
    settle(3);
    rd(novp_pkg::OFS_EXPECT, ALL, 32'hA, "inverse time");
    conclude();
  end
endmodule : tb_top
